//--- design/tpw_timer.sv
// five-channel 16-bit timer: synchronized preset/clear, pwm, reset-sync and complementary pairs
// assumes an apb master and a load on the pwm pins; one clock domain
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
// How it works
// RULE1: sync bit per channel joins synchronous operation
// RULE2: counter write loads all synchronized counters
// RULE3: sync-clear channels clear with another's clear
// RULE4: pwm pin A high on A, low on B
// RULE5: pwm forces compares; pin B keeps its function
// RULE6: equal compare registers leave pwm output unchanged
// RULE7: all five channels pwm, either clear source
// RULE8: clear on match gives 0% or 100% duty
// RULE9: pwm works with synchronized presets and clears
// RULE10: software sets pwm bit after setup
// RULE11: channels 3,4 give three pairs, counter 3 up
// RULE12: secondary output is inverted primary
// RULE13: counter 3 clears on period match, 4 free
// RULE14: outputs toggle on turning match and clear
// RULE15: software halts counter 3 while configuring
// RULE16: software sets period, then turning points
// RULE17: combo field picks reset-sync or complementary
// RULE18: complementary mode gives three non-overlapping pairs
// RULE19: match acts as counter leaves matching value
// RULE20: clock from system, prescaler or external edges
// RULE21: stopped counter holds outputs and count
// RULE22: synchronized channels start on same tick
module tpw_timer #(
  parameter int unsigned CW = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [3:0]              extClk,
  output logic [tpw_pkg::NCH-1:0]      captureComparePinA,
  output logic [tpw_pkg::NCH-1:0]      captureComparePinAOe,
  output logic [tpw_pkg::NCH-1:0]      captureComparePinB,
  output logic [tpw_pkg::NCH-1:0]      captureComparePinBOe,
  output logic                         inverseOutA4,
  output logic                         inverseOutB4,
  output logic                         inverseOutOe
);
  localparam int unsigned N = tpw_pkg::NCH;

  if (CW < 2 || CW > 32) begin : g_bad_width
    $error("tpw_timer: CW must be 2..32");
  end

  logic [N-1:0]          timerStartR;
  logic [N-1:0]          timerSyncR;
  logic [N-1:0]          pwmEnR;
  logic [1:0]            comboModeR;
  logic [8:0]            ctrlR [N];
  logic [CW-1:0]         cntR  [N];
  logic [CW-1:0]         graR  [N];
  logic [CW-1:0]         grbR  [N];
  logic [N-1:0]          pwmOutR;
  logic [N-1:0]          pinBOutR;
  logic [2:0]            posR;
  logic [2:0]            negR;
  logic [2:0]            posNxt;
  logic [2:0]            negNxt;
  logic [2:0]            preCntR;
  logic [N-1:0]          tick;
  logic [N-1:0]          cmpA;
  logic [N-1:0]          cmpB;
  logic [N-1:0]          ownClr;
  logic [N-1:0]          clr;
  logic [N-1:0]          wrCnt;
  logic [N-1:0]          load;
  logic                  syncClr;
  logic                  presetAll;
  logic                  wrStb;
  logic                  comboOn;
  logic                  comboRs;
  logic [2:0]            chSel;
  logic [3:0]            subSel;
  logic [31:0]           rdMux;
  logic [CW-1:0]         turn  [3];
  logic [2:0]            hit3;
  logic [2:0]            hit4;

  assign chSel   = paddr[6:4] - 3'h1;
  assign subSel  = paddr[3:0];
  assign comboOn = comboModeR[1];
  assign comboRs = comboModeR == tpw_pkg::COMBO_RSYNC;

  tpw_apb_if u_apb (
    .clk     (clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .rdMux   (rdMux),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .wrStb   (wrStb)
  );

  // global registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timerStartR <= '0;
      timerSyncR  <= '0;
      pwmEnR      <= '0;
      comboModeR  <= tpw_pkg::COMBO_OFF;
    end else if (wrStb && paddr[6:4] == 3'h0) begin
      // one write starts several channels on the same tick
      if (paddr[3:0] == tpw_pkg::OFF_START[3:0]) timerStartR <= pwdata[N-1:0]; // RULE22
      if (paddr[3:0] == tpw_pkg::OFF_SYNC[3:0]) timerSyncR <= pwdata[N-1:0]; // RULE1
      if (paddr[3:0] == tpw_pkg::OFF_MODE[3:0]) begin
        pwmEnR     <= pwdata[N-1:0]; // RULE10
        comboModeR <= pwdata[tpw_pkg::COMBO_LSB +: 2]; // RULE17
      end
    end
  end

  // shared prescaler keeps equal sources in phase across channels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCntR <= 3'h0;
    end else begin
      preCntR <= preCntR + 3'h1;
    end
  end

  always_comb begin
    for (int k = 0; k < N; k++) begin
      wrCnt[k] = wrStb && chSel == 3'(k) && subSel == tpw_pkg::SUB_CNT && paddr[6:4] != 3'h0;
    end
    presetAll = |(wrCnt & timerSyncR);
    syncClr   = |(ownClr & timerSyncR);
  end

  genvar i;
  for (i = 0; i < N; i++) begin : g_ch
    logic chWr;
    logic decoupled;
    tpw_pkg::tpw_clr_e clrSel;

    assign chWr      = wrStb && paddr[6:4] == 3'(i + 1);
    // channel 4 compares are cut off in the paired modes
    assign decoupled = comboOn && i == 4; // RULE13
    assign clrSel    = (comboOn && i == 3) ? tpw_pkg::CLR_GRA : tpw_pkg::tpw_clr_e'(ctrlR[i][tpw_pkg::CLR_LSB +: 2]);

    tpw_clk_sel u_cks (
      .clk     (clk),
      .rst_b   (rst_b),
      .run     (timerStartR[i]),
      .clkSel  (ctrlR[i][tpw_pkg::CKS_LSB +: 3]),
      .edgeSel (ctrlR[i][tpw_pkg::EDGE_LSB +: 2]),
      .preTick ({&preCntR, &preCntR[1:0], preCntR[0]}),
      .extClk  (extClk),
      .tick    (tick[i])
    );

    // match counts only as the counter steps off the value
    assign cmpA[i]   = tick[i] && cntR[i] == graR[i] && !decoupled; // RULE19
    assign cmpB[i]   = tick[i] && cntR[i] == grbR[i] && !decoupled; // RULE19
    assign ownClr[i] = (clrSel == tpw_pkg::CLR_GRA && cmpA[i]) || (clrSel == tpw_pkg::CLR_GRB && cmpB[i]); // RULE7 RULE8
    assign clr[i]    = ownClr[i] || (timerSyncR[i] && clrSel == tpw_pkg::CLR_SYNC && syncClr); // RULE3 RULE9
    assign load[i]   = wrCnt[i] || (presetAll && timerSyncR[i]); // RULE2

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        ctrlR[i] <= tpw_pkg::CTRL_RST;
        graR[i]  <= CW'(tpw_pkg::GR_RST);
        grbR[i]  <= CW'(tpw_pkg::GR_RST);
      end else if (chWr) begin
        if (subSel == tpw_pkg::SUB_CTRL) ctrlR[i] <= pwdata[8:0];
        if (subSel == tpw_pkg::SUB_GRA) graR[i] <= pwdata[CW-1:0];
        if (subSel == tpw_pkg::SUB_GRB) grbR[i] <= pwdata[CW-1:0];
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        cntR[i] <= '0;
      end else if (load[i]) begin
        cntR[i] <= pwdata[CW-1:0]; // RULE2
      end else if (clr[i]) begin
        cntR[i] <= '0; // RULE3 RULE13
      end else if (tick[i]) begin
        cntR[i] <= cntR[i] + CW'(1); // RULE11
      end
    end

    // both registers act as compares regardless of pin settings
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pwmOutR[i] <= 1'b0;
      end else if (pwmEnR[i] && cmpA[i] && !cmpB[i]) begin
        pwmOutR[i] <= 1'b1; // RULE4 RULE5 RULE6
      end else if (pwmEnR[i] && cmpB[i] && !cmpA[i]) begin
        pwmOutR[i] <= 1'b0; // RULE4
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pinBOutR[i] <= 1'b0;
      end else if (cmpB[i]) begin
        case (tpw_pkg::tpw_iob_e'(ctrlR[i][tpw_pkg::IOB_LSB +: 2]))
          tpw_pkg::IOB_LOW:    pinBOutR[i] <= 1'b0; // RULE5
          tpw_pkg::IOB_HIGH:   pinBOutR[i] <= 1'b1;
          tpw_pkg::IOB_TOGGLE: pinBOutR[i] <= ~pinBOutR[i];
          default:             pinBOutR[i] <= pinBOutR[i];
        endcase
      end
    end

    assign captureComparePinBOe[i] = (comboOn && i >= 3) || ctrlR[i][tpw_pkg::IOB_LSB +: 2] != tpw_pkg::IOB_OFF;
    assign captureComparePinAOe[i] = (comboOn && i >= 3) || pwmEnR[i]; // RULE7
  end

  // turning points against counter 3, and counter 4 for the negative side
  assign turn[0] = grbR[3];
  assign turn[1] = graR[4];
  assign turn[2] = grbR[4];

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      hit3[k] = tick[3] && cntR[3] == turn[k];
      hit4[k] = tick[4] && cntR[4] == turn[k];
    end
    // coincident match and clear cancel, giving a flat 0% or 100% phase
    posNxt = posR ^ hit3 ^ {3{clr[3]}}; // RULE14
    negNxt = comboRs ? ~posNxt : negR ^ hit4 ^ {3{clr[4]}}; // RULE12 RULE18
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      posR <= 3'h0;
      negR <= 3'h7;
    end else if (comboOn) begin
      posR <= posNxt; // RULE11 RULE14
      negR <= negNxt; // RULE12
    end
  end

  always_comb begin
    captureComparePinA = pwmOutR;
    captureComparePinB = pinBOutR;
    if (comboOn) begin
      captureComparePinA[3] = posR[0]; // RULE11 RULE18
      captureComparePinB[3] = negR[0];
      captureComparePinA[4] = posR[1];
      captureComparePinB[4] = posR[2];
    end
  end

  assign inverseOutA4 = comboOn & negR[1];
  assign inverseOutB4 = comboOn & negR[2];
  assign inverseOutOe = comboOn;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (paddr[6:4] == 3'h0) begin
      case (paddr[3:0])
        tpw_pkg::OFF_START[3:0]: rdMux[N-1:0] = timerStartR;
        tpw_pkg::OFF_SYNC[3:0]:  rdMux[N-1:0] = timerSyncR;
        tpw_pkg::OFF_MODE[3:0]:  rdMux = {22'h0, comboModeR, 3'h0, pwmEnR};
        default: rdMux = {20'h0, inverseOutB4, inverseOutA4, captureComparePinB, captureComparePinA};
      endcase
    end else if (chSel < 3'(N)) begin
      case (subSel)
        tpw_pkg::SUB_CTRL: rdMux[8:0] = ctrlR[chSel];
        tpw_pkg::SUB_CNT:  rdMux[CW-1:0] = cntR[chSel];
        tpw_pkg::SUB_GRA:  rdMux[CW-1:0] = graR[chSel];
        default:           rdMux[CW-1:0] = grbR[chSel];
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sync_preset: assert property (wrCnt[0] && timerSyncR[0] && timerSyncR[1] |=> cntR[1] == $past(pwdata[CW-1:0])) // RULE2
    else $error("synchronized preset missed");
  a_sync_clear: assert property (ownClr[0] && timerSyncR[0] && timerSyncR[1] && !load[1]
    && ctrlR[1][tpw_pkg::CLR_LSB +: 2] == tpw_pkg::CLR_SYNC |=> cntR[1] == '0) // RULE3
    else $error("synchronized clear missed");
  a_pwm_high: assert property (pwmEnR[0] && cmpA[0] && !cmpB[0] |=> captureComparePinA[0]) // RULE4
    else $error("pwm did not rise on A match");
  a_pwm_low: assert property (pwmEnR[1] && cmpB[1] && !cmpA[1] |=> !captureComparePinA[1]) // RULE4
    else $error("pwm did not fall on B match");
  a_pwm_equal: assert property (cmpA[0] && cmpB[0] |=> $stable(captureComparePinA[0])) // RULE6
    else $error("pwm moved on equal registers");
  a_stop_hold: assert property (!timerStartR[0] && !load[0] |=> $stable(cntR[0]) && $stable(pwmOutR[0])) // RULE21
    else $error("stopped channel changed");
  a_rs_clear: assert property (comboRs && tick[3] && cntR[3] == graR[3] && !load[3] |=> cntR[3] == '0) // RULE13
    else $error("counter 3 not cleared at period");
  a_rs_invert: assert property (comboRs && $past(comboRs) |-> captureComparePinB[3] != captureComparePinA[3]
    && inverseOutA4 != captureComparePinA[4]) // RULE12
    else $error("secondary not inverted");
  a_rs_toggle: assert property (comboRs && hit3[0] && !clr[3] |=> captureComparePinA[3] != $past(captureComparePinA[3])) // RULE14
    else $error("turning match did not toggle");
  a_tick_align: assert property (timerStartR[0] && timerStartR[1] && ctrlR[0][4:0] == ctrlR[1][4:0]
    && !ctrlR[0][2] |-> tick[0] == tick[1]) // RULE22
    else $error("synchronized ticks misaligned");

  // pin b, clock sources, pair toggles and counter 4 independence
  a_pin_b_high: assert property (cmpB[0] && ctrlR[0][8:7] == tpw_pkg::IOB_HIGH // RULE5
    |=> captureComparePinB[0])
    else $error("pin B missed its high level");
  a_stop_pins: assert property (!timerStartR[1] // RULE21
    |=> $stable(captureComparePinA[1]))
    else $error("stopped channel moved its pin");
  a_preset_pair: assert property (wrCnt[1] && timerSyncR[1] && timerSyncR[2] // RULE2
    |=> cntR[2] == cntR[1])
    else $error("synchronized counters differ after preset");
  a_group_only: assert property (wrCnt[0] && !timerSyncR[3] && !timerStartR[3] // RULE1
    |=> $stable(cntR[3]))
    else $error("unsynchronized counter was preset");
  a_div2_tick: assert property (tick[0] && ctrlR[0][2:0] == tpw_pkg::CKS_DIV2 // RULE20
    |=> !tick[0] || ctrlR[0][2:0] != tpw_pkg::CKS_DIV2)
    else $error("half-rate tick too fast");
  a_div8_tick: assert property (tick[0] && ctrlR[0][2:0] == tpw_pkg::CKS_DIV8 // RULE20
    |=> (!tick[0] || ctrlR[0][2:0] != tpw_pkg::CKS_DIV8) [*7])
    else $error("eighth-rate tick too fast");
  a_ext_rise: assert property (timerStartR[0] && ctrlR[0][4:0] == 5'h04 // RULE20
    |-> tick[0] == (extClk[0] && !$past(extClk[0])))
    else $error("external rising edge miscounted");
  a_ch4_free: assert property (comboOn && tick[4] && !load[4] && !timerSyncR[4] // RULE13
    |=> cntR[4] == $past(cntR[4]) + CW'(1))
    else $error("counter 4 not free running");
  a_rs_count_up: assert property (comboRs && tick[3] && !load[3] && !clr[3] // RULE11
    |=> cntR[3] == $past(cntR[3]) + CW'(1))
    else $error("counter 3 not counting up");
  a_rs_clr_toggle: assert property (comboRs && clr[3] && !hit3[1] // RULE14
    |=> captureComparePinA[4] != $past(captureComparePinA[4]))
    else $error("clear did not toggle pair output");
  a_rs_b4_toggle: assert property (comboRs && hit3[2] && !clr[3] // RULE14
    |=> captureComparePinB[4] != $past(captureComparePinB[4]))
    else $error("third turning match did not toggle");
  a_compl_sec: assert property (comboModeR == tpw_pkg::COMBO_COMPL && hit4[0] && !clr[4] // RULE18
    |=> captureComparePinB[3] != $past(captureComparePinB[3]))
    else $error("secondary did not toggle on counter 4");
endmodule // tpw_timer

//--- design/tpw_pkg.sv
// constants shared by the five-channel timer and pwm block
// assumes a 12-bit apb byte address and 32-bit data
package tpw_pkg;
  localparam int unsigned NCH = 5;
  localparam int unsigned CTRL_W = 9;
  // global register byte offsets
  localparam logic [11:0] OFF_START = 12'h000;
  localparam logic [11:0] OFF_SYNC  = 12'h004;
  localparam logic [11:0] OFF_MODE  = 12'h008;
  localparam logic [11:0] OFF_PINS  = 12'h00C;
  // channel n sits at 0x10 * (n + 1); sub offsets within it
  localparam logic [3:0] SUB_CTRL = 4'h0;
  localparam logic [3:0] SUB_CNT  = 4'h4;
  localparam logic [3:0] SUB_GRA  = 4'h8;
  localparam logic [3:0] SUB_GRB  = 4'hC;
  // control register field positions; COMBO_LSB is in the mode register
  localparam int unsigned CKS_LSB  = 0;
  localparam int unsigned EDGE_LSB = 3;
  localparam int unsigned CLR_LSB  = 5;
  localparam int unsigned IOB_LSB  = 7;
  localparam int unsigned COMBO_LSB = 8;
  // reset values
  localparam logic [8:0]  CTRL_RST = 9'h000;
  localparam logic [15:0] GR_RST   = 16'hFFFF;
  // clock select codes; 4..7 pick external pin 0..3
  localparam logic [2:0] CKS_SYS  = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  typedef enum logic [1:0] {CLR_NONE = 2'h0, CLR_GRA = 2'h1, CLR_GRB = 2'h2, CLR_SYNC = 2'h3} tpw_clr_e;
  typedef enum logic [1:0] {IOB_OFF = 2'h0, IOB_LOW = 2'h1, IOB_HIGH = 2'h2, IOB_TOGGLE = 2'h3} tpw_iob_e;
  typedef enum logic [1:0] {COMBO_OFF = 2'h0, COMBO_RSV = 2'h1, COMBO_RSYNC = 2'h2, COMBO_COMPL = 2'h3} tpw_combo_e;
endpackage

//--- design/tpw_clk_sel.sv
// per-channel count clock selection: system clock, prescaler taps, external pins
// assumes external pins are synchronous to clk
`timescale 1ns/1ps
module tpw_clk_sel (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [2:0] clkSel,
  input  wire logic [1:0] edgeSel,
  input  wire logic [2:0] preTick,
  input  wire logic [3:0] extClk,
  output logic            tick
);
  logic [3:0] extPrevR;
  logic       pinNow;
  logic       pinPrev;
  logic       extEdge;
  logic       srcTick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extPrevR <= 4'h0;
    end else begin
      extPrevR <= extClk;
    end
  end

  always_comb begin
    pinNow  = extClk[clkSel[1:0]];
    pinPrev = extPrevR[clkSel[1:0]];
    case (edgeSel)
      tpw_pkg::EDGE_RISE: extEdge = pinNow & ~pinPrev;
      tpw_pkg::EDGE_FALL: extEdge = ~pinNow & pinPrev;
      default:            extEdge = pinNow ^ pinPrev;
    endcase
    case (clkSel)
      tpw_pkg::CKS_SYS:  srcTick = 1'b1; // RULE20
      tpw_pkg::CKS_DIV2: srcTick = preTick[0];
      tpw_pkg::CKS_DIV4: srcTick = preTick[1];
      tpw_pkg::CKS_DIV8: srcTick = preTick[2];
      default:           srcTick = extEdge;
    endcase
    // stopped counter sees no tick at all
    tick = run & srcTick; // RULE21
  end
endmodule // tpw_clk_sel

//--- design/tpw_apb_if.sv
// apb slave handshake: decode, write strobe, registered read data
// assumes a zero-wait slave; read data sampled in the setup cycle
`timescale 1ns/1ps
module tpw_apb_if (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] rdMux,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             wrStb
);
  logic mapped;

  // 0x00..0x5C word aligned
  assign mapped  = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0) && (paddr[6:4] <= 3'h5);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  // unmapped writes are dropped
  assign wrStb   = psel & penable & pwrite & mapped;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= mapped ? rdMux : 32'h0000_0000;
    end
  end
endmodule // tpw_apb_if

//--- dv/tpw_load_model.sv
// load on the pwm pins: counts high cycles, rising edges and pair faults
// assumes pins change only at rising clk; an undriven pin reads low (pull-down)
`timescale 1ns/1ps
module tpw_load_model (
  input  wire logic             clk,
  input  wire logic             measClr,
  input  wire logic [4:0]       pinA,
  input  wire logic [4:0]       pinAOe,
  input  wire logic [4:0]       pinB,
  input  wire logic [4:0]       pinBOe,
  input  wire logic             invA4,
  input  wire logic             invB4,
  input  wire logic             invOe,
  output logic [4:0][15:0]      highA,
  output logic [4:0][15:0]      riseA,
  output logic [15:0]           highB4,
  output logic [15:0]           pairErr
);
  logic [4:0] lvlA;
  logic [4:0] lvlB;
  logic [4:0] lastA;
  logic [2:0] prim;
  logic [2:0] sec;
  // released pins fall to the pull-down, never keep the last level
  assign lvlA = pinA & pinAOe;
  assign lvlB = pinB & pinBOe;
  assign prim = {lvlB[4], lvlA[4], lvlA[3]};
  assign sec  = {invB4 & invOe, invA4 & invOe, lvlB[3]};
  always @(posedge clk) begin
    lastA <= lvlA;
    if (measClr) begin
      highA <= '0;
      riseA <= '0;
      highB4 <= '0;
      pairErr <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        highA[i] <= highA[i] + 16'(lvlA[i]);
        riseA[i] <= riseA[i] + 16'(lvlA[i] & ~lastA[i]);
      end
      highB4 <= highB4 + 16'(lvlB[4]);
      pairErr <= pairErr + 16'(prim != ~sec);
    end
  end
endmodule // tpw_load_model

//--- dv/testbench.sv
// bench for the timer: apb tasks, one task per scenario, load model on the pins
// assumes the zero-wait apb slave and register map of tpw_timer
`timescale 1ns/1ps
module testbench;
  logic             clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic             measClr, extDiv, err, iA4, iB4, iOe;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, c0;
  logic [3:0]       extClk;
  logic [4:0]       pA, pAOe, pB, pBOe;
  logic [4:0][15:0] highA, riseA;
  logic [15:0]      highB4, pairErr;
  int               error_cnt = 0;
  int               samples_checked = 0;
  int               cyc = 0;

  tpw_timer uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClk(extClk), .captureComparePinA(pA), .captureComparePinAOe(pAOe),
    .captureComparePinB(pB), .captureComparePinBOe(pBOe), .inverseOutA4(iA4),
    .inverseOutB4(iB4), .inverseOutOe(iOe));
  tpw_load_model load (.clk(clk), .measClr(measClr), .pinA(pA), .pinAOe(pAOe), .pinB(pB),
    .pinBOe(pBOe), .invA4(iA4), .invB4(iB4), .invOe(iOe), .highA(highA), .riseA(riseA),
    .highB4(highB4), .pairErr(pairErr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // external clock bit0 has a 4 clk period: pulses stay above 1.5 clk
  always @(posedge clk) begin
    extDiv <= ~extDiv;
    if (extDiv)
      extClk <= extClk + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task results();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held from setup until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chw(input int ch, input logic [3:0] sub, input logic [31:0] d);
    apb(1'b1, 12'(16 * (ch + 1)) | {8'h00, sub}, d);
  endtask

  task chr(input int ch, input logic [3:0] sub);
    apb(1'b0, 12'(16 * (ch + 1)) | {8'h00, sub}, 32'h0);
  endtask

  // window length a multiple of every period of a pin that moves, so phase does not matter
  task meas(input int n);
    @(posedge clk);
    measClr <= 1'b1;
    @(posedge clk);
    measClr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task t_reset();
    chk({22'h0, pA, pAOe}, 32'h0);
    chr(0, tpw_pkg::SUB_GRA);
    chk(rd, 32'h0000FFFF);
    apb(1'b0, tpw_pkg::OFF_MODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h060, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h064, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test done");
  endtask

  task pwm_run(input int ch, input logic [2:0] cks, input logic [1:0] edg, input logic [1:0] clr,
               input logic [15:0] a, input logic [15:0] b, input int hi, input int rises);
    apb(1'b1, tpw_pkg::OFF_START, 32'h0);
    chw(ch, tpw_pkg::SUB_CNT, 32'h0);
    chw(ch, tpw_pkg::SUB_CTRL, {23'h0, 2'h2, clr, edg, cks});
    chw(ch, tpw_pkg::SUB_GRA, {16'h0, a});
    chw(ch, tpw_pkg::SUB_GRB, {16'h0, b});
    apb(1'b1, tpw_pkg::OFF_MODE, 32'h1 << ch);
    apb(1'b1, tpw_pkg::OFF_START, 32'h1 << ch);
    repeat (40) @(posedge clk);
    meas(64);
    chk(32'(highA[ch]), 32'(hi));
    chk(32'(riseA[ch]), 32'(rises));
    chk({30'h0, pAOe[ch], pBOe[ch]}, 32'h3);
    apb(1'b0, tpw_pkg::OFF_PINS, 32'h0);
    chk({31'h0, rd[5 + ch]}, 32'h1);
  endtask

  task automatic t_pwm();
    int cs [7] = '{1, 2, 3, 4, 4, 4, 5};
    int eg [7] = '{0, 0, 0, 0, 1, 2, 0};
    int rs [7] = '{8, 4, 2, 4, 4, 8, 2};
    for (int ch = 0; ch < 5; ch++)
      pwm_run(ch, tpw_pkg::CKS_SYS, 2'h0, tpw_pkg::CLR_GRB, 16'h1, 16'h3, 32, 16);
    pwm_run(0, tpw_pkg::CKS_SYS, 2'h0, tpw_pkg::CLR_GRB, 16'h7, 16'h4, 0, 0);
    pwm_run(0, tpw_pkg::CKS_SYS, 2'h0, tpw_pkg::CLR_GRA, 16'h4, 16'h7, 64, 0);
    pwm_run(0, tpw_pkg::CKS_SYS, 2'h0, tpw_pkg::CLR_GRB, 16'h3, 16'h3, 64, 0);
    for (int k = 0; k < 7; k++)
      pwm_run(0, 3'(cs[k]), 2'(eg[k]), tpw_pkg::CLR_GRB, 16'h1, 16'h3, 32, rs[k]);
    apb(1'b1, tpw_pkg::OFF_START, 32'h0);
    chr(0, tpw_pkg::SUB_CNT);
    c0 = rd;
    meas(30);
    chk(32'(riseA[0]), 32'h0);
    chr(0, tpw_pkg::SUB_CNT);
    chk(rd, c0);
    $display("pwm and clock test done");
  endtask

  task t_sync();
    apb(1'b1, tpw_pkg::OFF_START, 32'h0);
    apb(1'b1, tpw_pkg::OFF_SYNC, 32'h7);
    chw(3, tpw_pkg::SUB_CNT, 32'h0);
    chw(1, tpw_pkg::SUB_CNT, 32'h1234);
    for (int ch = 0; ch < 4; ch++) begin
      chr(ch, tpw_pkg::SUB_CNT);
      chk(rd, (ch == 3) ? 32'h0 : 32'h1234);
    end
    apb(1'b1, tpw_pkg::OFF_SYNC, 32'h3);
    chw(0, tpw_pkg::SUB_CTRL, {25'h0, tpw_pkg::CLR_GRB, 5'h0});
    chw(0, tpw_pkg::SUB_GRA, 32'h2);
    chw(0, tpw_pkg::SUB_GRB, 32'h9);
    chw(1, tpw_pkg::SUB_CTRL, {25'h0, tpw_pkg::CLR_SYNC, 5'h0});
    chw(1, tpw_pkg::SUB_GRA, 32'h5);
    chw(1, tpw_pkg::SUB_GRB, 32'h7);
    chw(0, tpw_pkg::SUB_CNT, 32'h0);
    apb(1'b1, tpw_pkg::OFF_MODE, 32'h3);
    apb(1'b1, tpw_pkg::OFF_START, 32'h3);
    repeat (30) @(posedge clk);
    meas(100);
    chk(32'(highA[0]), 32'h46);
    chk(32'(highA[1]), 32'h14);
    chk(32'(riseA[1]), 32'hA);
    apb(1'b1, tpw_pkg::OFF_START, 32'h0);
    chr(0, tpw_pkg::SUB_CNT);
    c0 = rd;
    chr(1, tpw_pkg::SUB_CNT);
    chk(rd, c0);
    $display("synchronized test done");
  endtask

  task t_rsync();
    apb(1'b1, tpw_pkg::OFF_START, 32'h0);
    apb(1'b1, tpw_pkg::OFF_SYNC, 32'h0);
    chw(3, tpw_pkg::SUB_CTRL, {25'h0, tpw_pkg::CLR_GRA, 5'h0});
    chw(4, tpw_pkg::SUB_CTRL, {25'h0, tpw_pkg::CLR_GRA, 5'h0});
    apb(1'b1, tpw_pkg::OFF_MODE, {22'h0, tpw_pkg::COMBO_RSYNC, 8'h0});
    chw(3, tpw_pkg::SUB_CNT, 32'h0);
    chw(4, tpw_pkg::SUB_CNT, 32'h0);
    chw(3, tpw_pkg::SUB_GRA, 32'h9);
    chw(3, tpw_pkg::SUB_GRB, 32'h3);
    chw(4, tpw_pkg::SUB_GRA, 32'h5);
    chw(4, tpw_pkg::SUB_GRB, 32'h7);
    apb(1'b1, tpw_pkg::OFF_START, 32'h18);
    repeat (30) @(posedge clk);
    meas(100);
    chk(32'(highA[3]), 32'h3C);
    chk(32'(highA[4]), 32'h28);
    chk(32'(highB4), 32'h14);
    chk(32'(pairErr), 32'h0);
    chk({24'h0, iOe, pAOe[4:3], pBOe[4:3], 3'h0}, 32'hF8);
    apb(1'b1, tpw_pkg::OFF_START, 32'h0);
    chr(4, tpw_pkg::SUB_CNT);
    chk({31'h0, rd > 32'h9}, 32'h1);
    $display("reset-synchronized test done");
  endtask

  task t_compl();
    apb(1'b1, tpw_pkg::OFF_MODE, {22'h0, tpw_pkg::COMBO_COMPL, 8'h0});
    chw(3, tpw_pkg::SUB_CNT, 32'h2);
    chw(4, tpw_pkg::SUB_CNT, 32'h0);
    apb(1'b1, tpw_pkg::OFF_START, 32'h18);
    repeat (20) @(posedge clk);
    chk({27'h0, iOe, pAOe[4:3], pBOe[4:3]}, 32'h1F);
    $display("complementary test done");
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    extClk = 4'h0;
    extDiv = 1'b0;
    measClr = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_pwm();
    t_sync();
    t_rsync();
    t_compl();
    results();
  end
endmodule // testbench
